// >>> src/dfc_regs.svh
// constants of the decimation filter chain
`ifndef DFC_REGS_SVH
`define DFC_REGS_SVH

// ----------------------------------------
// ratio decoding
// ----------------------------------------
`define DFC_LOG2_TURBO     4'h6
`define DFC_LOG2_BASE      4'h7
`define DFC_SINC3_LOG2_MAX 4'hA
`define DFC_FAST_CONVS     2'h2
`define DFC_OUT_MSB        23

// ----------------------------------------
// settling times in master clock periods
// ----------------------------------------
`define DFC_SETTLE_64      16'd728
`define DFC_SETTLE_128     16'd856
`define DFC_SETTLE_256     16'd1112
`define DFC_SETTLE_512     16'd1624
`define DFC_SETTLE_1024    16'd2648
`define DFC_SETTLE_2048    16'd4696
`define DFC_SETTLE_4096    16'd8792
`define DFC_SETTLE_8192    16'd16984
`define DFC_SETTLE_16384   16'd33368

`endif

// >>> src/dfc_pkg.sv
// types of the decimation filter chain
package dfc_pkg;

   typedef enum logic {
      PATH_FAST,
      PATH_SINC3
   } dfc_path_t;

   typedef struct packed {
      logic [3:0] logTotal;
      logic [3:0] logSinc3;
      logic [2:0] logSinc1;
      logic       cascade;
   } dfc_cfg_t;

   typedef struct packed {
      logic [23:0] data1;
      logic [23:0] data0;
   } dfc_result_t;

   typedef struct packed {
      logic [39:0] int1;
      logic [39:0] int2;
      logic [39:0] int3;
      logic [39:0] dly1;
      logic [39:0] dly2;
      logic [39:0] dly3;
      logic [39:0] cascAcc;
      logic [39:0] fastAcc;
      logic [23:0] sincOut;
      logic [23:0] fastOut;
   } dfc_chain_state_t;

endpackage

// >>> src/dfc_chain.sv
// one channel: sinc3 path, optional sinc1 stage and fast-settling path
`timescale 1ns/1ps
`include "dfc_regs.svh"

module dfc_chain
   import dfc_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rstSync_n,
   // timing from the shared sequencer
   input  wire logic        modEn,
   input  wire logic        sinc3Tick,
   input  wire logic        outTick,
   input  wire dfc_cfg_t    cfg,
   // modulator stream and restart
   input  wire logic        modBit,
   input  wire logic        restart,
   // results
   output logic      [23:0] sincResult,
   output logic      [23:0] fastResult
);

   dfc_chain_state_t st_reg;
   dfc_chain_state_t st_next;

   // scale a value of +/-2^magLog to the 24-bit output range, saturating
   function automatic logic [23:0] scaleOut(input logic [39:0] v, input logic [5:0] magLog);
      logic signed [39:0] w;
      w = $signed(v);
      if (magLog <= 6'(`DFC_OUT_MSB))
         w = w <<< (6'(`DFC_OUT_MSB) - magLog);
      else
         w = w >>> (magLog - 6'(`DFC_OUT_MSB));
      if (w > 40'sh00_007F_FFFF)
         scaleOut = 24'h7F_FFFF;
      else if (w < -40'sh00_0080_0000)
         scaleOut = 24'h80_0000;
      else
         scaleOut = w[23:0];
   endfunction

   always_comb begin
      logic [39:0] x;
      logic [39:0] c1;
      logic [39:0] c2;
      logic [39:0] c3;
      logic [5:0]  sincMag;
      x       = modBit ? 40'h00_0000_0001 : 40'hFF_FFFF_FFFF;
      c1      = '0;
      c2      = '0;
      c3      = '0;
      sincMag = cfg.cascade ? 6'(30) + 6'(cfg.logSinc1) : 6'(3) * 6'(cfg.logSinc3);
      st_next = st_reg;
      if (restart) begin
         // clears history so settling starts over
         st_next.int1    = '0;
         st_next.int2    = '0;
         st_next.int3    = '0;
         st_next.dly1    = '0;
         st_next.dly2    = '0;
         st_next.dly3    = '0;
         st_next.cascAcc = '0;
         st_next.fastAcc = '0;
         if (outTick) begin
            // a held-off channel reports its cleared filter
            st_next.sincOut = '0;
            st_next.fastOut = '0;
         end
      end else if (modEn) begin
         // both paths see every modulator sample
         st_next.int1 = st_reg.int1 + x;
         st_next.int2 = st_reg.int2 + st_next.int1;
         st_next.int3 = st_reg.int3 + st_next.int2;
         if (sinc3Tick) begin
            // cubed (1-z^-N)/(1-z^-1) comb section, nulls at rate multiples
            c1 = st_next.int3 - st_reg.dly1;
            c2 = c1 - st_reg.dly2;
            c3 = c2 - st_reg.dly3;
            st_next.dly1 = st_next.int3;
            st_next.dly2 = c1;
            st_next.dly3 = c2;
            if (cfg.cascade) begin
               // sinc1 averaging after a fixed 1024 sinc3
               if (outTick) begin
                  st_next.sincOut = scaleOut(st_reg.cascAcc + c3, sincMag);
                  st_next.cascAcc = '0;
               end else begin
                  st_next.cascAcc = st_reg.cascAcc + c3;
               end
            end else if (outTick) begin
               st_next.sincOut = scaleOut(c3, sincMag);
            end
         end
         // boxcar over the full ratio
         if (outTick) begin
            st_next.fastOut = scaleOut(st_reg.fastAcc + x, 6'(cfg.logTotal));
            st_next.fastAcc = '0;
         end else begin
            st_next.fastAcc = st_reg.fastAcc + x;
         end
      end
   end

   always_ff @(posedge mclk or negedge rstSync_n) begin
      if (!rstSync_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign sincResult = st_reg.sincOut;
   assign fastResult = st_reg.fastOut;

endmodule

// >>> src/dfc_top.sv
// decimation filter chain for two delta-sigma channels
`timescale 1ns/1ps
`include "dfc_regs.svh"

module dfc_top
   import dfc_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // modulator streams, bit 0 is channel 0
   input  wire logic [1:0]  modBits,
   // ratio selection
   input  wire logic [2:0]  decimationSelect,
   input  wire logic        turboRatioEnable,
   // channel events
   input  wire logic [1:0]  channelEnable,
   input  wire logic [1:0]  muxGainChange,
   input  wire logic        resync,
   // results
   output dfc_result_t      result,
   output logic            resultReady_n,
   output logic            sinc3Active,
   output logic     [15:0] settleCycles
);

   typedef struct packed {
      logic        modPhase;
      logic [13:0] sampleCnt;
      logic [1:0]  convCnt;
      dfc_path_t   path;
      logic        outDly;
      logic        readyN;
      dfc_result_t data;
      logic [15:0] settle;
   } dfc_top_state_t;

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic rstMeta_reg;
   logic rstSync_reg;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_reg <= 1'b0;
         rstSync_reg <= 1'b0;
      end else begin
         rstMeta_reg <= 1'b1;
         rstSync_reg <= rstMeta_reg;
      end
   end

   // ----------------------------------------
   // ratio decoding and settling table
   // ----------------------------------------
   function automatic dfc_cfg_t decodeRatio(input logic [2:0] sel, input logic turbo);
      dfc_cfg_t c;
      c.logTotal = turbo ? `DFC_LOG2_TURBO : `DFC_LOG2_BASE + {1'b0, sel};
      c.cascade  = c.logTotal > `DFC_SINC3_LOG2_MAX;
      c.logSinc3 = c.cascade ? `DFC_SINC3_LOG2_MAX : c.logTotal;
      c.logSinc1 = 3'(c.logTotal - c.logSinc3);
      return c;
   endfunction

   function automatic logic [15:0] settleFor(input logic [3:0] logTotal);
      case (logTotal)
         4'h6:    settleFor = `DFC_SETTLE_64;
         4'h7:    settleFor = `DFC_SETTLE_128;
         4'h8:    settleFor = `DFC_SETTLE_256;
         4'h9:    settleFor = `DFC_SETTLE_512;
         4'hA:    settleFor = `DFC_SETTLE_1024;
         4'hB:    settleFor = `DFC_SETTLE_2048;
         4'hC:    settleFor = `DFC_SETTLE_4096;
         4'hD:    settleFor = `DFC_SETTLE_8192;
         default: settleFor = `DFC_SETTLE_16384;
      endcase
   endfunction

   dfc_cfg_t       cfg;
   dfc_top_state_t st_reg;
   dfc_top_state_t st_next;
   logic           modEn;
   logic           sinc3Tick;
   logic           outTick;
   logic [13:0]    mask3;
   logic [13:0]    maskN;
   logic [1:0]     enPrev_reg;
   logic [1:0]     restart;
   logic [23:0]    sincResult [2];
   logic [23:0]    fastResult [2];

   assign cfg   = decodeRatio(decimationSelect, turboRatioEnable);
   assign mask3 = 14'((15'h0001 << cfg.logSinc3) - 15'h0001);
   assign maskN = 14'((15'h0001 << cfg.logTotal) - 15'h0001);
   // one modulator sample every second master clock
   assign modEn = st_reg.modPhase;
   // same strobes for both chains
   assign sinc3Tick = modEn && ((st_reg.sampleCnt & mask3) == mask3);
   assign outTick   = modEn && ((st_reg.sampleCnt & maskN) == maskN);

   // ----------------------------------------
   // channel restart events
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rstSync_reg) begin
      if (!rstSync_reg)
         enPrev_reg <= 2'h0;
      else
         enPrev_reg <= channelEnable;
   end

   // disabled channels stay cleared; enable edges restart
   assign restart = ~channelEnable | (channelEnable & ~enPrev_reg) | muxGainChange
                  | {2{resync}};

   for (genvar ch = 0; ch < 2; ch++) begin : g_chain
      dfc_chain u_chain (
         .mclk       (mclk),
         .rstSync_n  (rstSync_reg),
         .modEn      (modEn),
         .sinc3Tick  (sinc3Tick),
         .outTick    (outTick),
         .cfg        (cfg),
         .modBit     (modBits[ch]),
         .restart    (restart[ch]),
         .sincResult (sincResult[ch]),
         .fastResult (fastResult[ch])
      );
   end

   // ----------------------------------------
   // sequencer and output selection
   // ----------------------------------------
   always_comb begin
      st_next          = st_reg;
      st_next.modPhase = ~st_reg.modPhase;
      st_next.outDly   = outTick;
      st_next.readyN   = 1'b1;
      st_next.settle   = settleFor(cfg.logTotal);
      if (resync) begin
         // realign conversion boundaries
         st_next.modPhase  = 1'b0;
         st_next.sampleCnt = '0;
         st_next.outDly    = 1'b0;
      end else if (modEn) begin
         st_next.sampleCnt = st_reg.sampleCnt + 14'h0001;
      end
      if (st_reg.outDly) begin
         // results issued whether settled or not
         st_next.readyN = 1'b0;
         unique case (st_reg.path)
            PATH_FAST: begin
               st_next.data.data0 = fastResult[0];
               st_next.data.data1 = fastResult[1];
               st_next.convCnt    = st_reg.convCnt + 2'h1;
               if (st_reg.convCnt + 2'h1 == `DFC_FAST_CONVS)
                  st_next.path = PATH_SINC3;
            end
            PATH_SINC3: begin
               st_next.data.data0 = sincResult[0];
               st_next.data.data1 = sincResult[1];
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstSync_reg) begin
      if (!rstSync_reg) begin
         st_reg        <= '0;
         st_reg.path   <= PATH_FAST;
         st_reg.readyN <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign result        = st_reg.data;
   assign resultReady_n = st_reg.readyN;
   assign sinc3Active   = st_reg.path == PATH_SINC3;
   assign settleCycles  = st_reg.settle;

endmodule

// >>> bench/dfc_top_checker.sv
// assertions on the ports of the decimation filter chain
`timescale 1ns/1ps
module dfc_top_checker
   import dfc_pkg::*;
(
   // clock and reset
   input wire logic        mclk,
   input wire logic        rst_n,
   // controls
   input wire logic [2:0]  decimationSelect,
   input wire logic        turboRatioEnable,
   input wire logic [1:0]  channelEnable,
   input wire logic        resync,
   // outputs
   input wire dfc_result_t result,
   input wire logic        resultReady_n,
   input wire logic        sinc3Active,
   input wire logic [15:0] settleCycles
);
   localparam int SETTLE [9] = '{728, 856, 1112, 1624, 2648, 4696, 8792, 16984, 33368};
   logic [15:0] gapCnt_reg;
   logic [15:0] dis1Cnt_reg;
   logic [2:0]  upCnt_reg;
   logic [1:0]  rdyCnt_reg;
   logic        gapValid_reg;
   int          nCur;
   int          expSettle;
   assign nCur = turboRatioEnable ? 64 : (128 << decimationSelect);
   assign expSettle = turboRatioEnable ? SETTLE[0] : SETTLE[int'(decimationSelect) + 1];
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         gapCnt_reg   <= 16'h0000;
         dis1Cnt_reg  <= 16'h0000;
         upCnt_reg    <= 3'h0;
         rdyCnt_reg   <= 2'h0;
         gapValid_reg <= 1'b0;
      end else begin
         gapCnt_reg   <= resultReady_n ? gapCnt_reg + 16'h0001 : 16'h0000;
         dis1Cnt_reg  <= channelEnable[1] ? 16'h0000 : dis1Cnt_reg + {15'h0000, ~&dis1Cnt_reg};
         upCnt_reg    <= upCnt_reg + {2'h0, ~&upCnt_reg};
         rdyCnt_reg   <= rdyCnt_reg + {1'b0, ~resultReady_n & ~&rdyCnt_reg};
         gapValid_reg <= (resync || $changed(decimationSelect) || $changed(turboRatioEnable))
                         ? 1'b0 : (gapValid_reg || !resultReady_n);
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence seqStrobe;
      !resultReady_n ##1 resultReady_n;
   endsequence
   a_strobe_gap: assert property (seqStrobe |-> resultReady_n [*8])
      else $error("ready strobe malformed");
   a_result_stands: assert property ($changed(result) |-> !resultReady_n)
      else $error("result moved without ready");
   a_path_sticky: assert property (sinc3Active |=> sinc3Active)
      else $error("sinc3 path dropped");
   a_path_switch: assert property ($rose(sinc3Active) |->
      (rdyCnt_reg == 2'h1 && !resultReady_n) || (rdyCnt_reg == 2'h2 && $past(resultReady_n) == 1'b0))
      else $error("path switch not at second result");
   a_path_late: assert property (rdyCnt_reg == 2'h3 |-> sinc3Active)
      else $error("still on fast path");
   a_settle_table: assert property (upCnt_reg == 3'h7 && $stable(decimationSelect)
      && $stable(turboRatioEnable) |-> settleCycles == 16'(expSettle))
      else $error("settle time wrong");
   a_conv_spacing: assert property (!resultReady_n && gapValid_reg
      |-> gapCnt_reg == 16'(2 * nCur - 1))
      else $error("conversion spacing wrong");
   a_disabled_clear: assert property (!resultReady_n && dis1Cnt_reg > 16'(2 * nCur + 8)
      |-> result.data1 == 24'h00_0000)
      else $error("disabled channel not cleared");
endmodule

// >>> bench/dfc_host_model.sv
// host model: takes each result and times settling on its own
`timescale 1ns/1ps
module dfc_host_model
   import dfc_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // device side
   input  wire logic        resultReady_n,
   input  wire dfc_result_t result,
   // settling events and time
   input  wire logic        settleEvt,
   input  wire logic [31:0] settleTime,
   // taken results
   output logic             takeStrobe,
   output dfc_result_t      takenData,
   output logic             takenSettled
);
   int elapsed;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         elapsed    <= 0;
         takeStrobe <= 1'b0;
      end else begin
         elapsed    <= settleEvt ? 0 : elapsed + 1;
         takeStrobe <= !resultReady_n;
         if (!resultReady_n) begin
            takenData    <= result;
            takenSettled <= elapsed >= settleTime;
         end
      end
   end
endmodule

// >>> bench/test_dfc_top.sv
// self-checking bench of the decimation filter chain
`timescale 1ns/1ps
module test_dfc_top;
   import dfc_pkg::*;
   logic        mclk = 1'b0;
   logic        rst_n = 1'b0;
   logic [2:0]  decimationSelect = 3'h0;
   logic        turboRatioEnable = 1'b1;
   logic [1:0]  channelEnable = 2'h3;
   logic [1:0]  muxGainChange = 2'h0;
   logic        resync = 1'b0;
   logic        settleEvt = 1'b0;
   logic [1:0]  pat = 2'h0;
   logic [1:0]  altCnt = 2'h0;
   logic [1:0]  modBits;
   logic        resultReady_n;
   logic        sinc3Active;
   logic        takeStrobe;
   logic        takenSettled;
   logic        lastSettled;
   logic [15:0] settleCycles;
   dfc_result_t result;
   dfc_result_t takenData;
   int          settleTime = 728;
   int          error_cnt = 0;
   int          checks = 0;
   int          seed = 24536;
   int          convIdx = 0;
   int          k;
   int          i;
   int          act;
   int          SETTLE [9] = '{728, 856, 1112, 1624, 2648, 4696, 8792, 16984, 33368};
   always #20 mclk = ~mclk;
   // ones where pat is set, else a +1/-1 alternation per sample
   always @(negedge mclk) altCnt <= altCnt + 2'h1;
   assign modBits = pat | {2{altCnt[1]}};
   dfc_top dfc_top_inst (.mclk(mclk), .rst_n(rst_n), .modBits(modBits),
      .decimationSelect(decimationSelect), .turboRatioEnable(turboRatioEnable),
      .channelEnable(channelEnable), .muxGainChange(muxGainChange), .resync(resync),
      .result(result), .resultReady_n(resultReady_n), .sinc3Active(sinc3Active),
      .settleCycles(settleCycles));
   dfc_host_model dfc_host_model_inst (.mclk(mclk), .rst_n(rst_n),
      .resultReady_n(resultReady_n), .result(result), .settleEvt(settleEvt),
      .settleTime(settleTime), .takeStrobe(takeStrobe), .takenData(takenData),
      .takenSettled(takenSettled));
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // model: ones give full scale, alternation and a disabled channel give zero
   function automatic logic [23:0] expOf(input int c);
      return (channelEnable[c] && pat[c]) ? 24'h7F_FFFF : 24'h00_0000;
   endfunction
   task automatic conv();
      @(negedge mclk);
      for (i = 0; i < 40000 && takeStrobe !== 1'b1; i++) @(negedge mclk);
      if (i == 40000) begin
         error_cnt++;
         tally_and_finish();
      end
      convIdx++;
      lastSettled = takenSettled;
      if (convIdx <= 2 || takenSettled === 1'b1) begin
         cmp(takenData.data0, expOf(0));
         cmp(takenData.data1, expOf(1));
      end
   endtask
   task automatic event_pulse();
      settleEvt = 1'b1;
      @(negedge mclk);
      settleEvt = 1'b0;
      muxGainChange = 2'h0;
      resync = 1'b0;
      lastSettled = 1'b0;
   endtask
   initial begin
      pat = 2'($random(seed));
      repeat (10) @(negedge mclk);
      cmp(result.data0 | result.data1, 24'h00_0000);
      cmp({resultReady_n, sinc3Active, 6'h00, settleCycles}, 24'h80_0000);
      rst_n = 1'b1;
      conv();
      conv();
      cmp({23'h00_0000, sinc3Active}, 24'h00_0001);
      for (k = 0; k < 12; k++) begin
         act = $random(seed) & 3;
         channelEnable[1] = (act != 3);
         case (act)
            0: pat = 2'($random(seed));
            1: muxGainChange = 2'($random(seed)) | 2'h1;
            2: resync = 1'b1;
            default: ;
         endcase
         event_pulse();
         for (int j = 0; j < 12 && !lastSettled; j++) conv();
         conv();
      end
      for (k = 0; k < 9; k++) begin
         turboRatioEnable = (k == 0);
         decimationSelect = 3'(k - 1);
         repeat (2) @(negedge mclk);
         cmp({8'h00, settleCycles}, 24'(SETTLE[k]));
      end
      for (k = 2; k < 6; k += 3) begin
         decimationSelect = 3'(k - 1);
         settleTime = SETTLE[k];
         pat = 2'($random(seed));
         resync = 1'b1;
         event_pulse();
         for (int j = 0; j < 4 && !lastSettled; j++) conv();
      end
      tally_and_finish();
   end
endmodule
bind dfc_top dfc_top_checker dfc_top_checker_inst (.mclk(mclk), .rst_n(rst_n),
   .decimationSelect(decimationSelect), .turboRatioEnable(turboRatioEnable),
   .channelEnable(channelEnable), .resync(resync), .result(result),
   .resultReady_n(resultReady_n), .sinc3Active(sinc3Active), .settleCycles(settleCycles));
